/* File: logic/hotswap_off_pkg.sv */
// Package with register map, field positions and timing for the turn-off logic.
package hotswap_off_pkg;

    // ****************************************************************
    // Register offsets.
    // ****************************************************************
    localparam logic [7:0] OFF_CONTROL_CONFIG = 8'h00;
    localparam logic [7:0] OFF_FAULT_HISTORY  = 8'h04;
    localparam logic [7:0] OFF_CURRENT_TRIM   = 8'h11;

    // ****************************************************************
    // Control register fields.
    // ****************************************************************
    localparam int CTL_UV_RETRY   = 0;
    localparam int CTL_OV_RETRY   = 1;
    localparam int CTL_OC_RETRY   = 2;
    localparam int CTL_SWITCH_CMD = 3;
    localparam int CTL_SENSE_POL  = 5;
    localparam int CTL_HIST_MASK  = 7;

    // ****************************************************************
    // Fault history fields.
    // ****************************************************************
    localparam int FH_INPUT_HIGH = 0;
    localparam int FH_INPUT_LOW  = 1;
    localparam int FH_OVERCUR    = 2;
    localparam int FH_SENSE_CHG  = 4;
    localparam int FH_DEGRADED   = 6;

    // ****************************************************************
    // Trim field and reset values.
    // ****************************************************************
    localparam int TRIM_LSB = 5;
    localparam int TRIM_MSB = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h27;
    localparam logic [7:0] HISTORY_RESET = 8'h00;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int CLK_MHZ          = 200;
    localparam int SUPPLY_QUAL_NS   = 2000;
    localparam int SUPPLY_QUAL_CYC  = SUPPLY_QUAL_NS * CLK_MHZ / 1000;
    localparam int COOL_CYCLES      = 256;

endpackage

/* File: logic/hotswap_turnoff_overcurrent_ctrl.sv */
// Turn-off, circuit-breaker, cool-down and power-good control logic.
`timescale 1ns/100ps
// Function
// - A change of the connection sense to its off state starts a switch-off.
// - Writing zero to control bit 3 switches the pass transistor drive off.
// - Input high, input low, overcurrent and degraded faults stop the drive.
// - A set fault bit 0-2 or 6 whose auto-retry is off holds the drive off.
// - The power-good pin goes low once feedback reports the output low.
// - Input or internal supply low held past 2 us forces a fast shutdown.
// - Trim bits 7-5 at 0x11 select the current-limit sense threshold.
// - The trim takes its default from storage and is host writable.
// - During current limiting the delay ramps up and trips at its top.
// - If limiting ends before the top the delay ramps back down.
// - After a trip the delay falls to its bottom, then cycles 256 times.
// - Restart after cool-down needs overcurrent retry or a cleared bit.
// - Power good waits for feedback high and gate enhancement both.
// - Control bit 3 follows sense edges and host writes.
// - A sense toggle sets history bit 4 and clears others unless masked.

module hotswap_turnoff_overcurrent_ctrl
    import hotswap_off_pkg::*;
#(
    parameter int COOL_COUNT = COOL_CYCLES
)(
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [7:0] i_nv_control,
    input  wire logic [7:0] i_nv_trim,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic       i_conn_sense,
    input  wire logic       i_input_high_fault,
    input  wire logic       i_input_low_fault,
    input  wire logic       i_switch_degraded_fault,
    input  wire logic       i_current_limit,
    input  wire logic       i_timer_high,
    input  wire logic       i_timer_low,
    input  wire logic       i_output_feedback_input,
    input  wire logic       i_gate_enhanced,
    input  wire logic       i_supply_low,
    input  wire logic       i_internal_supply_low,
    input  wire logic       i_pg_mode,
    output logic            o_gate_on,
    output logic            o_fast_shutdown,
    output logic            o_timer_up,
    output logic            o_timer_down,
    output logic [2:0]      o_limit_select,
    output logic            o_first_general_pin_oe
);

    // ****************************************************************
    // State and registers.
    // ****************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_TRIP_FALL, ST_COOL_UP,
                              ST_COOL_DOWN} cb_state_t;

    cb_state_t   cb_q, cb_d;
    logic [7:0]  control_q, control_d;
    logic [7:0]  history_q, history_d;
    logic [7:0]  trim_q, trim_d;
    logic [8:0]  cool_q, cool_d;
    logic [9:0]  qual_q;
    logic        sense_q;
    logic        loaded_q;
    logic        pg_q, pg_d;
    logic        fast_q;

    // ****************************************************************
    // Decode.
    // ****************************************************************
    // Input thresholds are already synchronous single bits.
    wire logic sense_on   = i_conn_sense == control_q[CTL_SENSE_POL];
    wire logic sense_prev = sense_q == control_q[CTL_SENSE_POL];
    wire logic sense_tog  = loaded_q && (sense_on != sense_prev);
    wire logic wr_ctl     = i_reg_wr && i_reg_addr == OFF_CONTROL_CONFIG;
    wire logic wr_hist    = i_reg_wr && i_reg_addr == OFF_FAULT_HISTORY;
    wire logic wr_trim    = i_reg_wr && i_reg_addr == OFF_CURRENT_TRIM;
    wire logic supply_bad = i_supply_low || i_internal_supply_low;
    wire logic qual_done  = qual_q >= 10'(SUPPLY_QUAL_CYC);
    wire logic trip       = cb_q == ST_IDLE && i_current_limit &&
                            i_timer_high;
    // The last counted bottom crossing ends the cool-down.
    wire logic [8:0] cool_next = cool_q + 9'h001;
    wire logic cool_end   = cb_q == ST_COOL_DOWN && i_timer_low &&
                            cool_next >= 9'(COOL_COUNT);

    // Latched faults hold the switch off while their retry is disabled.
    wire logic hold_off =
        (history_q[FH_INPUT_HIGH] && !control_q[CTL_OV_RETRY]) ||
        (history_q[FH_INPUT_LOW]  && !control_q[CTL_UV_RETRY]) ||
        (history_q[FH_OVERCUR]    && !control_q[CTL_OC_RETRY]) ||
        (history_q[FH_DEGRADED]   && !control_q[CTL_OC_RETRY]);
    wire logic fault_now = i_input_high_fault || i_input_low_fault ||
                           i_switch_degraded_fault;

    // ****************************************************************
    // Control and history next state.
    // ****************************************************************
    // Sense edges set or clear the switch command, host writes too.
    always_comb
    begin
        control_d = control_q;
        if (wr_ctl)
            control_d = i_reg_wdata;
        if (sense_tog)
            control_d[CTL_SWITCH_CMD] = sense_on;
    end

    // Hardware-set fault bits win over a host clear in the same cycle.
    always_comb
    begin
        history_d = history_q;
        if (wr_hist)
            history_d = i_reg_wdata;
        if (sense_tog && !control_q[CTL_HIST_MASK])
            history_d = HISTORY_RESET;
        if (sense_tog)
            history_d[FH_SENSE_CHG] = 1'b1;
        if (i_input_high_fault)
            history_d[FH_INPUT_HIGH] = 1'b1;
        if (i_input_low_fault)
            history_d[FH_INPUT_LOW] = 1'b1;
        if (i_switch_degraded_fault)
            history_d[FH_DEGRADED] = 1'b1;
        if (trip)
            history_d[FH_OVERCUR] = 1'b1;
    end

    // Trim is host writable after its storage default.
    assign trim_d = wr_trim ? i_reg_wdata : trim_q;

    // ****************************************************************
    // Circuit-breaker and cool-down sequencer.
    // ****************************************************************
    always_comb
    begin
        cb_d   = cb_q;
        cool_d = cool_q;
        unique case (cb_q)
            ST_IDLE:
                if (trip)
                begin
                    cb_d   = ST_TRIP_FALL;
                    cool_d = 9'h000;
                end
            ST_TRIP_FALL:
                if (i_timer_low)
                    cb_d = ST_COOL_UP;
            ST_COOL_UP:
                if (i_timer_high)
                    cb_d = ST_COOL_DOWN;
            ST_COOL_DOWN:
                if (i_timer_low)
                begin
                    cool_d = cool_next;
                    if (cool_end)
                        cb_d = ST_IDLE;
                    else
                        cb_d = ST_COOL_UP;
                end
        endcase
    end

    // Timer drive: up while limiting in ST_IDLE or while cooling up, else down.
    assign o_timer_up   = (cb_q == ST_IDLE && i_current_limit) ||
                          cb_q == ST_COOL_UP;
    assign o_timer_down = !o_timer_up;

    // Restart only with retry on or the overcurrent bit cleared.
    wire logic cb_block = cb_q != ST_IDLE || cool_end || trip;

    // Gate drive combines command, live and latched faults.
    assign o_gate_on = control_q[CTL_SWITCH_CMD] && !fault_now &&
                       !hold_off && !cb_block && !fast_q && !trip;

    // Power good needs feedback and enhancement, drops with feedback.
    always_comb
    begin
        pg_d = pg_q;
        if (!i_output_feedback_input || !o_gate_on)
            pg_d = 1'b0;
        else if (i_gate_enhanced)
            pg_d = 1'b1;
    end

    // Open-drain pin pulls low when power is not good in that mode.
    assign o_first_general_pin_oe = i_pg_mode && !pg_q;
    assign o_fast_shutdown        = fast_q;
    assign o_limit_select         = trim_q[TRIM_MSB:TRIM_LSB];

    // Register read mux, unmapped offsets read zero.
    assign o_reg_rdata = (i_reg_addr == OFF_CONTROL_CONFIG) ? control_q :
                         (i_reg_addr == OFF_FAULT_HISTORY)  ? history_q :
                         (i_reg_addr == OFF_CURRENT_TRIM)   ? trim_q    :
                         8'h00;

    // ****************************************************************
    // Registers.
    // ****************************************************************
    // Storage defaults are loaded in the first cycle after reset.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            control_q <= CONTROL_RESET;
            trim_q    <= 8'h00;
            loaded_q  <= 1'b0;
        end
        else if (!loaded_q)
        begin
            control_q <= i_nv_control;
            trim_q    <= i_nv_trim;
            loaded_q  <= 1'b1;
        end
        else
        begin
            control_q <= control_d;
            trim_q    <= trim_d;
        end
    end

    // Fault history, sequencer and power good.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            history_q <= HISTORY_RESET;
            cb_q      <= ST_IDLE;
            cool_q    <= 9'h000;
            pg_q      <= 1'b0;
            sense_q   <= 1'b0;
        end
        else
        begin
            history_q <= history_d;
            cb_q      <= cb_d;
            cool_q    <= cool_d;
            pg_q      <= pg_d;
            sense_q   <= i_conn_sense;
        end
    end

    // Supply-low qualification counter and latched fast shutdown.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            qual_q <= 10'h000;
            fast_q <= 1'b0;
        end
        else
        begin
            qual_q <= !supply_bad ? 10'h000 :
                      qual_done ? qual_q : qual_q + 10'h001;
            fast_q <= (supply_bad && qual_done) ||
                      (fast_q && control_q[CTL_SWITCH_CMD]);
        end
    end

endmodule // hotswap_turnoff_overcurrent_ctrl

/* File: verif/hotswap_off_chk.sv */
// Assertion checker for the turn-off control block ports.
`timescale 1ns/100ps
module hotswap_off_chk
    import hotswap_off_pkg::*;
(
    input wire logic       i_ref_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_conn_sense,
    input wire logic       i_input_high_fault,
    input wire logic       i_input_low_fault,
    input wire logic       i_switch_degraded_fault,
    input wire logic       i_current_limit,
    input wire logic       i_timer_high,
    input wire logic       i_output_feedback_input,
    input wire logic       i_gate_enhanced,
    input wire logic       i_supply_low,
    input wire logic       i_internal_supply_low,
    input wire logic       i_pg_mode,
    input wire logic       o_gate_on,
    input wire logic       o_fast_shutdown,
    input wire logic       o_timer_up,
    input wire logic [2:0] o_limit_select,
    input wire logic       o_first_general_pin_oe
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    int bad_q;
    // Counts how long a supply has stayed low without a break.
    always_ff @(posedge i_ref_clk)
        bad_q <= (i_sys_rst || !(i_supply_low || i_internal_supply_low))
                 ? 0 : bad_q + 1;
    AST_FAULT_OFF: assert property (
        (i_input_high_fault || i_input_low_fault || i_switch_degraded_fault)
        |-> !o_gate_on) else $error("gate on in fault");
    AST_CMD_OFF: assert property (
        i_reg_wr && i_reg_addr == OFF_CONTROL_CONFIG &&
        !i_reg_wdata[CTL_SWITCH_CMD] && $stable(i_conn_sense)
        |=> !o_gate_on) else $error("gate on after off command");
    AST_TRIP_OFF: assert property (
        i_current_limit && i_timer_high |-> !o_gate_on)
        else $error("gate on at breaker trip");
    AST_RAMP_UP: assert property (
        o_gate_on && i_current_limit |-> o_timer_up)
        else $error("delay not rising in limit");
    AST_RAMP_DOWN: assert property (
        o_gate_on && !i_current_limit |-> !o_timer_up)
        else $error("delay not falling");
    AST_FAST_TRIP: assert property (
        bad_q >= SUPPLY_QUAL_CYC + 2 |-> o_fast_shutdown)
        else $error("no fast shutdown");
    AST_FAST_OFF: assert property (
        o_fast_shutdown |-> !o_gate_on)
        else $error("gate on in fast shutdown");
    AST_TRIM: assert property (
        i_reg_wr && i_reg_addr == OFF_CURRENT_TRIM
        |=> o_limit_select == 3'($past(i_reg_wdata) >> TRIM_LSB))
        else $error("trim select wrong");
    AST_PG_LOW: assert property (
        i_pg_mode && !i_output_feedback_input ##1 i_pg_mode
        |-> o_first_general_pin_oe) else $error("pin not low");
    AST_PG_BOTH: assert property (
        $fell(o_first_general_pin_oe) && i_pg_mode && $past(i_pg_mode)
        |-> $past(i_output_feedback_input) && $past(i_gate_enhanced))
        else $error("early power good");
    COV_TRIP: cover property (i_current_limit && i_timer_high);
    COV_FAST: cover property ($rose(o_fast_shutdown));
    COV_PG: cover property ($fell(o_first_general_pin_oe));
endmodule // hotswap_off_chk
bind hotswap_turnoff_overcurrent_ctrl hotswap_off_chk chk_u (.*);

/* File: verif/hotswap_timer_model.sv */
// Behavioural model of the circuit-breaker timing capacitor.
`timescale 1ns/100ps
module hotswap_timer_model #(
    parameter int RAMP = 6
)(
    input  wire logic i_ref_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_up,
    output logic      o_top,
    output logic      o_bottom
);
    int         level_q;
    logic [1:0] slow_q;
    // Charges a step each cycle and discharges four times slower.
    always_ff @(posedge i_ref_clk)
    begin
        slow_q <= i_sys_rst ? 2'h0 : slow_q + 2'h1;
        if (i_sys_rst)
            level_q <= 0;
        else if (i_up && level_q < RAMP)
            level_q <= level_q + 1;
        else if (!i_up && level_q > 0 && slow_q == 2'h3)
            level_q <= level_q - 1;
    end
    // Thresholds reach the block as clocked single bits.
    assign o_top    = (level_q >= RAMP);
    assign o_bottom = (level_q == 0);
endmodule // hotswap_timer_model

/* File: verif/test_hotswap_turnoff_overcurrent_ctrl.sv */
// Self-checking bench for the turn-off control block.
`timescale 1ns/100ps
module test_hotswap_turnoff_overcurrent_ctrl;
    import hotswap_off_pkg::*;
    logic i_ref_clk = 0, i_sys_rst = 1, i_reg_wr = 0, i_conn_sense = 1;
    logic i_input_high_fault = 0, i_input_low_fault = 0, i_pg_mode = 0;
    logic i_switch_degraded_fault = 0, i_current_limit = 0;
    logic i_output_feedback_input = 0, i_gate_enhanced = 0;
    logic i_supply_low = 0, i_internal_supply_low = 0;
    logic i_timer_high, i_timer_low, o_gate_on, o_fast_shutdown;
    logic o_timer_up, o_timer_down, o_first_general_pin_oe;
    logic [7:0] i_nv_control = 8'h2C, i_nv_trim = 8'hA0, o_reg_rdata;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, d;
    logic [2:0] o_limit_select;
    int errors = 0, comparisons = 0;
    int hb[3] = '{FH_INPUT_HIGH, FH_INPUT_LOW, FH_DEGRADED};
    string nm[6] = '{"rdata", "gate", "limit", "pg_oe", "fast", "timer"};
    typedef struct {int sel; logic [7:0] exp;} note_t;
    note_t notes[$];
    event look;
    hotswap_turnoff_overcurrent_ctrl #(.COOL_COUNT(4)) dut_u (.*);
    hotswap_timer_model #(.RAMP(6)) cap_u (.i_ref_clk, .i_sys_rst,
        .i_up(o_timer_up), .o_top(i_timer_high), .o_bottom(i_timer_low));
    initial forever #2.5 i_ref_clk = ~i_ref_clk;
    function automatic logic [7:0] view(int sel);
        case (sel)
            0: return o_reg_rdata;
            1: return {7'h00, o_gate_on};
            2: return {5'h00, o_limit_select};
            3: return {7'h00, o_first_general_pin_oe};
            4: return {7'h00, o_fast_shutdown};
            default: return {6'h00, o_timer_up, o_timer_down};
        endcase
    endfunction
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Takes the oldest note and compares it with the output it names.
    initial forever
    begin
        @(look);
        check(nm[notes[0].sel], view(notes[0].sel), notes[0].exp);
        void'(notes.pop_front());
    end
    task automatic note(int sel, logic [7:0] exp);
        notes.push_back('{sel, exp});
        ->look;
        #1;
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(negedge i_ref_clk);
        i_reg_wr = 1;
        i_reg_addr = a;
        i_reg_wdata = v;
        @(negedge i_ref_clk);
        i_reg_wr = 0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge i_ref_clk);
        i_reg_addr = a;
        #1 note(0, exp);
    endtask
    task automatic gate_is(logic v, int lim);
        repeat (lim) if (o_gate_on !== v) @(negedge i_ref_clk);
        note(1, {7'h00, v});
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog cuts a hung run short.
    initial
    begin
        #(20000 * 5);
        errors++;
        tally_and_finish();
    end
    initial
    begin
        void'($urandom(3608));
        i_nv_trim = 8'($urandom);
        cyc(10);
        i_sys_rst = 0;
        cyc(2);
        rd(OFF_CONTROL_CONFIG, 8'h2C);
        rd(OFF_CURRENT_TRIM, i_nv_trim);
        note(2, {5'h00, i_nv_trim[7:5]});
        gate_is(1, 2);
        wr(OFF_CONTROL_CONFIG, 8'h24);
        gate_is(0, 1);
        wr(OFF_CONTROL_CONFIG, 8'h2C);
        wr(8'h22, 8'hFF);
        rd(8'h22, 8'h00);
        repeat (4)
        begin
            d = 8'($urandom);
            wr(OFF_CURRENT_TRIM, d);
            note(2, {5'h00, d[7:5]});
            rd(OFF_CURRENT_TRIM, d);
        end
        $display("test registers done");
        for (int k = 0; k < 3; k++)
        begin
            {i_switch_degraded_fault, i_input_low_fault, i_input_high_fault}
                = 3'h1 << k;
            #1 note(1, 8'h00);
            cyc(2);
            {i_switch_degraded_fault, i_input_low_fault, i_input_high_fault}
                = 3'h0;
            cyc(3);
            if (k < 2) note(1, 8'h00);
            rd(OFF_FAULT_HISTORY, 8'(8'h01 << hb[k]));
            wr(OFF_FAULT_HISTORY, 8'h00);
            gate_is(1, 2000);
        end
        $display("test faults done");
        i_current_limit = 1;
        #1 note(5, 8'h02);
        cyc(3);
        i_current_limit = 0;
        gate_is(1, 1);
        note(5, 8'h01);
        cyc(40);
        i_current_limit = 1;
        gate_is(0, 100);
        cyc(1);
        i_current_limit = 0;
        rd(OFF_FAULT_HISTORY, 8'h04);
        cyc(140);
        gate_is(0, 1);
        gate_is(1, 300);
        wr(OFF_FAULT_HISTORY, 8'h00);
        wr(OFF_CONTROL_CONFIG, 8'h28);
        i_current_limit = 1;
        gate_is(0, 100);
        cyc(1);
        i_current_limit = 0;
        cyc(300);
        gate_is(0, 1);
        wr(OFF_FAULT_HISTORY, 8'h00);
        gate_is(1, 20);
        wr(OFF_CONTROL_CONFIG, 8'h2C);
        $display("test breaker done");
        i_pg_mode = 1;
        i_output_feedback_input = 1;
        cyc(3);
        note(3, 8'h01);
        i_gate_enhanced = 1;
        cyc(2);
        note(3, 8'h00);
        i_output_feedback_input = 0;
        cyc(2);
        note(3, 8'h01);
        $display("test power good done");
        for (int k = 0; k < 2; k++)
        begin
            {i_internal_supply_low, i_supply_low} = 2'h1 << k;
            cyc(SUPPLY_QUAL_CYC - 10);
            note(4, 8'h00);
            cyc(15);
            note(4, 8'h01);
            gate_is(0, 1);
            {i_internal_supply_low, i_supply_low} = 2'h0;
            wr(OFF_CONTROL_CONFIG, 8'h24);
            wr(OFF_CONTROL_CONFIG, 8'h2C);
            gate_is(1, 20);
        end
        $display("test fast shutdown done");
        i_input_high_fault = 1;
        cyc(1);
        i_input_high_fault = 0;
        i_conn_sense = 0;
        cyc(2);
        gate_is(0, 1);
        rd(OFF_FAULT_HISTORY, 8'h10);
        rd(OFF_CONTROL_CONFIG, 8'h24);
        wr(OFF_CONTROL_CONFIG, 8'hA4);
        i_input_high_fault = 1;
        cyc(1);
        i_input_high_fault = 0;
        i_conn_sense = 1;
        cyc(2);
        rd(OFF_FAULT_HISTORY, 8'h11);
        rd(OFF_CONTROL_CONFIG, 8'hAC);
        $display("test sense done");
        tally_and_finish();
    end
endmodule // test_hotswap_turnoff_overcurrent_ctrl
